// *** logic/vsc_defs.svh ***
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

// Clock rate
`define VSC_CLK_MHZ 100

// Timeout select locations, written by address only
`define VSC_TSEL_BASE 32'hfe3a0000
`define VSC_TSEL_B0_CLR 32'hfe3a0000
`define VSC_TSEL_B0_SET 32'hfe3a0001
`define VSC_TSEL_B1_CLR 32'hfe3a0002
`define VSC_TSEL_B1_SET 32'hfe3a0003
`define VSC_TSEL_RESET 2'h0

// Status readback location
`define VSC_STATUS_ADDR 32'hfe3a0010

// Interrupt control locations
`define VSC_SYSFAIL_EN_ADDR 32'hfe28003b
`define VSC_SYSFAIL_DIS_ADDR 32'hfe28003f
`define VSC_GRP7_CPUX_ADDR 32'hfe394001
`define VSC_GRP7_CPUY_ADDR 32'hfe39c001

// Status field positions
`define VSC_ST_ACTIVE 0
`define VSC_ST_RR 1
`define VSC_ST_TSEL_LO 2
`define VSC_ST_SYSFAIL_EN 4
`define VSC_ST_GRP_X 5
`define VSC_ST_GRP_Y 6
`define VSC_ST_OWNED 7

// Times in nanoseconds and derived cycle counts (round up)
`define VSC_ARB_TO_NS 10000
`define VSC_BERR_32US_NS 32000
`define VSC_BERR_256US_NS 256000
`define VSC_BERR_1MS_NS 1000000
`define VSC_ACFAIL_DLY_NS 100000
`define VSC_SYSRST_HOLD_NS 200000
`define VSC_NS2CYC(ns) (((ns) * `VSC_CLK_MHZ + 999) / 1000)
`define VSC_ARB_TO_CYC `VSC_NS2CYC(`VSC_ARB_TO_NS)
`define VSC_BERR_32US_CYC `VSC_NS2CYC(`VSC_BERR_32US_NS)
`define VSC_BERR_256US_CYC `VSC_NS2CYC(`VSC_BERR_256US_NS)
`define VSC_BERR_1MS_CYC `VSC_NS2CYC(`VSC_BERR_1MS_NS)
`define VSC_ACFAIL_DLY_CYC `VSC_NS2CYC(`VSC_ACFAIL_DLY_NS)
`define VSC_SYSRST_HOLD_CYC `VSC_NS2CYC(`VSC_SYSRST_HOLD_NS)

`endif

// *** logic/vsc_pkg.sv ***
`default_nettype none
package vsc_pkg;

    typedef enum logic [1:0] {
        VSC_ARB_IDLE,
        VSC_ARB_GRANT,
        VSC_ARB_OWNED
    } vsc_arb_state_t;

    // Timeout select code {second bit, first bit}
    typedef enum logic [1:0] {
        VSC_TO_32US = 2'h0,
        VSC_TO_256US = 2'h1,
        VSC_TO_1MS = 2'h2,
        VSC_TO_NEVER = 2'h3
    } vsc_tsel_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } vsc_regbus_t;

    typedef struct packed {
        logic [3:0] req;
        logic busy;
    } vsc_arb_in_t;

endpackage : vsc_pkg
`default_nettype wire

// *** logic/vsc_top.sv ***
// Contract
// - Controller functions only in first slot; acfail and parity level 7 interrupts are not gated by slot
// - Force-disable input suppresses all controller functions; acfail and parity level 7 interrupts still reach the CPUs
// - Four request levels, priority or round-robin
// - Priority mode grants highest level, 3 first
// - Round-robin examines next level after release
// - Round-robin skips levels without pending request
// - Mode input high selects round-robin
// - Only one arbiter active on backplane
// - Arbitration cycle times out after 10 us
// - Wired-or acknowledge drives first daisy output
// - Bus error when strobes exceed timeout
// - Timeout is 32 us after power-up or board reset, kept through power-fail reset
// - Four address locations set/clear select bits
// - Select writes ignore the data value
// - System reset at power-up, board reset, power-fail
// - Drive system clock from 16 MHz oscillator
// - Only one board drives system clock
// - SysFail interrupt off by default, write-controlled
// - SysFail in level 7 group, group enable
// - Level 7 group steered to one CPU
`include "vsc_defs.svh"
`default_nettype none
module vsc_top #(
    parameter logic [19:0] BERR_256US_CYC = 20'(`VSC_BERR_256US_CYC),
    parameter logic [19:0] BERR_1MS_CYC = 20'(`VSC_BERR_1MS_CYC),
    parameter logic [19:0] ACFAIL_DLY_CYC = 20'(`VSC_ACFAIL_DLY_CYC),
    parameter logic [19:0] SYSRST_HOLD_CYC = 20'(`VSC_SYSRST_HOLD_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire vsc_pkg::vsc_regbus_t regbus,
    output logic [7:0] rdata,
    input wire logic slot1_detect,
    input wire logic cfg_force_disable,
    input wire logic cfg_round_robin,
    input wire vsc_pkg::vsc_arb_in_t arb_in,
    output logic [3:0] bus_grant,
    input wire logic iack_in,
    output logic iack_chain_out,
    input wire logic ds0,
    input wire logic ds1,
    output logic berr_o,
    output logic berr_oe,
    input wire logic board_reset_in,
    input wire logic acfail_in,
    output logic sysreset_o,
    output logic sysreset_oe,
    input wire logic osc16_in,
    output logic sysclk_o,
    output logic sysclk_oe,
    input wire logic sysfail_in,
    input wire logic parity_err_in,
    output logic irq7_cpu_x,
    output logic irq7_cpu_y
);

    localparam logic [9:0] ARB_TO_CYC = 10'(`VSC_ARB_TO_CYC);
    localparam logic [19:0] BERR_32US_CYC = 20'(`VSC_BERR_32US_CYC);

    logic slot_reg;
    logic captured_reg;
    logic active_reg;
    vsc_pkg::vsc_arb_state_t state_reg;
    logic [1:0] grant_lvl_reg;
    logic grant_on_reg;
    logic [1:0] last_reg;
    logic [9:0] arb_cnt_reg;
    logic [1:0] tsel_reg;
    logic [19:0] ds_cnt_reg;
    logic berr_reg;
    logic [19:0] berr_limit;
    logic ds_any;
    logic iack_reg;
    logic sysreset_reg;
    logic [19:0] hold_cnt_reg;
    logic [19:0] acf_cnt_reg;
    logic acf_done_reg;
    logic acf_fire;
    logic sysfail_en_reg;
    logic grp_x_reg;
    logic grp_y_reg;
    logic irq_x_reg;
    logic irq_y_reg;
    logic [7:0] rdata_reg;
    logic [1:0] pick_lvl;
    wire logic [3:0] req = arb_in.req;
    wire logic wr = regbus.wr;
    wire logic [31:0] addr = regbus.addr;

    // Slot detection caught once after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slot_reg <= 1'b0;
            captured_reg <= 1'b0;
        end else if (!captured_reg) begin
            slot_reg <= slot1_detect;
            captured_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= slot_reg & captured_reg & ~cfg_force_disable;
        end
    end

    // Level selection for the next grant
    function automatic logic [1:0] vsc_pick(input logic [3:0] r, input logic rr,
                                            input logic [1:0] last);
        logic [1:0] sel;
        logic found;
        logic [1:0] idx;
        sel = 2'h0;
        found = 1'b0;
        idx = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (!rr && r[i]) begin
                sel = 2'(i);
            end
        end
        for (int i = 1; i <= 4; i++) begin
            idx = last + 2'(i);
            if (rr && r[idx] && !found) begin
                sel = idx;
                found = 1'b1;
            end
        end
        return sel;
    endfunction : vsc_pick
    assign pick_lvl = vsc_pick(req, cfg_round_robin, last_reg);

    always_ff @(posedge clk) begin
        if (!rst_n || !active_reg) begin
            state_reg <= vsc_pkg::VSC_ARB_IDLE;
            grant_on_reg <= 1'b0;
            grant_lvl_reg <= 2'h0;
            last_reg <= 2'h0;
            arb_cnt_reg <= 10'h0;
        end else begin
            case (state_reg)
                vsc_pkg::VSC_ARB_IDLE: begin
                    arb_cnt_reg <= 10'h0;
                    if (req != 4'h0) begin
                        grant_on_reg <= 1'b1;
                        grant_lvl_reg <= pick_lvl;
                        last_reg <= pick_lvl;
                        state_reg <= vsc_pkg::VSC_ARB_GRANT;
                    end
                end
                vsc_pkg::VSC_ARB_GRANT: begin
                    if (arb_in.busy) begin
                        grant_on_reg <= 1'b0;
                        state_reg <= vsc_pkg::VSC_ARB_OWNED;
                    end else if (arb_cnt_reg == ARB_TO_CYC - 10'h1) begin
                        grant_on_reg <= 1'b0;
                        state_reg <= vsc_pkg::VSC_ARB_IDLE;
                    end else begin
                        arb_cnt_reg <= arb_cnt_reg + 10'h1;
                    end
                end
                vsc_pkg::VSC_ARB_OWNED: begin
                    if (!arb_in.busy) begin
                        state_reg <= vsc_pkg::VSC_ARB_IDLE;
                    end
                end
                default: begin
                    state_reg <= vsc_pkg::VSC_ARB_IDLE;
                    grant_on_reg <= 1'b0;
                end
            endcase
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_grant
        assign bus_grant[g] = grant_on_reg && (grant_lvl_reg == 2'(g));
    end

    // Acknowledge daisy chain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            iack_reg <= 1'b0;
        end else begin
            iack_reg <= active_reg & iack_in;
        end
    end
    assign iack_chain_out = iack_reg;

    // Timeout select, address decode only
    always_ff @(posedge clk) begin
        if (!rst_n || board_reset_in) begin
            tsel_reg <= `VSC_TSEL_RESET;
        end else if (wr) begin
            case (addr)
                `VSC_TSEL_B0_CLR: tsel_reg[0] <= 1'b0;
                `VSC_TSEL_B0_SET: tsel_reg[0] <= 1'b1;
                `VSC_TSEL_B1_CLR: tsel_reg[1] <= 1'b0;
                `VSC_TSEL_B1_SET: tsel_reg[1] <= 1'b1;
                default: tsel_reg <= tsel_reg;
            endcase
        end
    end

    always_comb begin
        case (vsc_pkg::vsc_tsel_t'(tsel_reg))
            vsc_pkg::VSC_TO_32US: berr_limit = BERR_32US_CYC;
            vsc_pkg::VSC_TO_256US: berr_limit = BERR_256US_CYC;
            vsc_pkg::VSC_TO_1MS: berr_limit = BERR_1MS_CYC;
            default: berr_limit = 20'h0;
        endcase
    end

    assign ds_any = ds0 | ds1;
    always_ff @(posedge clk) begin
        if (!rst_n || !active_reg || !ds_any) begin
            ds_cnt_reg <= 20'h0;
            berr_reg <= 1'b0;
        end else if (tsel_reg != 2'(vsc_pkg::VSC_TO_NEVER)) begin
            if (ds_cnt_reg >= berr_limit - 20'h1) begin
                berr_reg <= 1'b1;
            end else begin
                ds_cnt_reg <= ds_cnt_reg + 20'h1;
            end
        end
    end
    assign berr_o = 1'b0;
    assign berr_oe = berr_reg;

    // Power-fail delay
    always_ff @(posedge clk) begin
        if (!rst_n || !acfail_in) begin
            acf_cnt_reg <= 20'h0;
            acf_done_reg <= 1'b0;
        end else if (!acf_done_reg) begin
            if (acf_cnt_reg == ACFAIL_DLY_CYC - 20'h1) begin
                acf_done_reg <= 1'b1;
            end else begin
                acf_cnt_reg <= acf_cnt_reg + 20'h1;
            end
        end
    end
    assign acf_fire = acfail_in && !acf_done_reg && (acf_cnt_reg == ACFAIL_DLY_CYC - 20'h1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sysreset_reg <= 1'b1;
            hold_cnt_reg <= 20'h0;
        end else if (board_reset_in || acf_fire) begin
            sysreset_reg <= 1'b1;
            hold_cnt_reg <= 20'h0;
        end else if (sysreset_reg) begin
            if (hold_cnt_reg == SYSRST_HOLD_CYC - 20'h1) begin
                sysreset_reg <= 1'b0;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 20'h1;
            end
        end
    end
    assign sysreset_o = 1'b0;
    assign sysreset_oe = sysreset_reg & active_reg;

    // Buffered oscillator onto the backplane clock
    assign sysclk_o = osc16_in & active_reg;
    assign sysclk_oe = active_reg;

    // SysFail enable and level 7 group steering
    always_ff @(posedge clk) begin
        if (!rst_n || board_reset_in) begin
            sysfail_en_reg <= 1'b0;
        end else if (wr && addr == `VSC_SYSFAIL_EN_ADDR) begin
            sysfail_en_reg <= 1'b1;
        end else if (wr && addr == `VSC_SYSFAIL_DIS_ADDR) begin
            sysfail_en_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || board_reset_in) begin
            grp_x_reg <= 1'b0;
            grp_y_reg <= 1'b0;
        end else if (wr && (addr == `VSC_GRP7_CPUX_ADDR || addr == `VSC_GRP7_CPUY_ADDR)) begin
            grp_x_reg <= (addr == `VSC_GRP7_CPUX_ADDR);
            grp_y_reg <= (addr == `VSC_GRP7_CPUY_ADDR);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_x_reg <= 1'b0;
            irq_y_reg <= 1'b0;
        end else begin
            irq_x_reg <= grp_x_reg & (acfail_in | parity_err_in |
                         (sysfail_in & sysfail_en_reg & active_reg));
            irq_y_reg <= grp_y_reg & (acfail_in | parity_err_in |
                         (sysfail_in & sysfail_en_reg & active_reg));
        end
    end
    assign irq7_cpu_x = irq_x_reg;
    assign irq7_cpu_y = irq_y_reg;

    // Status readback, zero elsewhere and outside the answer cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (regbus.rd && addr == `VSC_STATUS_ADDR) begin
            rdata_reg <= 8'h00;
            rdata_reg[`VSC_ST_ACTIVE] <= active_reg;
            rdata_reg[`VSC_ST_RR] <= cfg_round_robin;
            rdata_reg[`VSC_ST_TSEL_LO +: 2] <= tsel_reg;
            rdata_reg[`VSC_ST_SYSFAIL_EN] <= sysfail_en_reg;
            rdata_reg[`VSC_ST_GRP_X] <= grp_x_reg;
            rdata_reg[`VSC_ST_GRP_Y] <= grp_y_reg;
            rdata_reg[`VSC_ST_OWNED] <= (state_reg == vsc_pkg::VSC_ARB_OWNED);
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign rdata = rdata_reg;

    // Same cycle: active rises two edges after release, grants are cleared while it is low
    active_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !active_reg |-> (bus_grant == 4'h0 && !sysclk_oe))
        else $error("grant or clock while inactive");
    one_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot0(bus_grant))
        else $error("more than one grant");
    prio_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (active_reg && state_reg == vsc_pkg::VSC_ARB_IDLE && !cfg_round_robin && req[3])
        |=> bus_grant[3])
        else $error("level 3 not granted first");
    rr_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
        (active_reg && state_reg == vsc_pkg::VSC_ARB_IDLE && cfg_round_robin && req != 4'h0)
        |=> (bus_grant != 4'h0 && (bus_grant & ~$past(req)) == 4'h0))
        else $error("rotation granted an idle level");
    arb_timeout_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == vsc_pkg::VSC_ARB_GRANT && !arb_in.busy &&
         arb_cnt_reg == ARB_TO_CYC - 10'h1) |=> (bus_grant == 4'h0))
        else $error("grant not withdrawn on timeout");
    iack_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        active_reg |=> (iack_chain_out == $past(iack_in)))
        else $error("acknowledge chain not following");
    berr_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ds_any |=> !berr_oe)
        else $error("bus error held without strobe");
    berr_never_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tsel_reg == 2'h3) |-> !$rose(berr_oe))
        else $error("bus error in never setting");
    tsel_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == `VSC_TSEL_B0_SET && !board_reset_in) |=> tsel_reg[0])
        else $error("select bit not set by address");
    reset_gen_a: assert property (@(posedge clk) disable iff (!rst_n)
        board_reset_in |=> sysreset_reg [*2])
        else $error("system reset not generated");
    sysfail_dis_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == `VSC_SYSFAIL_DIS_ADDR) |=> !sysfail_en_reg)
        else $error("sysfail not disabled");
    group_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !grp_x_reg |=> !irq7_cpu_x)
        else $error("group interrupt while disabled");
    steer_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(grp_x_reg && grp_y_reg))
        else $error("group steered to both cpus");

endmodule : vsc_top
`default_nettype wire

// *** tb/vsc_vme_masters.sv ***
`default_nettype none
module vsc_vme_masters (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] bus_grant,
    input wire logic [3:0] raise,
    input wire logic ignore,
    input wire logic [7:0] take_dly,
    output vsc_pkg::vsc_arb_in_t arb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pend;
    logic busy;
    logic [7:0] cnt;
    logic [7:0] order[$];

    // Boards sharing one level merge into one pending bit
    assign arb.req = pend;
    // Requesters only: no arbiter and no clock driver here
    assign arb.busy = busy;

    always @(posedge clk) begin
        if (!rst_n) begin
            pend <= 4'h0;
            busy <= 1'b0;
            cnt <= 8'h00;
            order.delete();
        end else if (busy) begin
            pend <= pend | raise;
            if (cnt == 8'h00) begin
                busy <= 1'b0;
            end else begin
                cnt <= cnt - 8'h01;
            end
        end else if ((|bus_grant) && !ignore && cnt >= take_dly) begin
            // Take the bus and drop the winning request
            pend <= (pend | raise) & ~bus_grant;
            busy <= 1'b1;
            cnt <= 8'h05;
            for (int i = 0; i < 4; i++) begin
                if (bus_grant[i]) begin
                    order.push_back(8'(i));
                end
            end
        end else begin
            pend <= pend | raise;
            cnt <= ((|bus_grant) && !ignore) ? cnt + 8'h01 : 8'h00;
        end
    end
endmodule : vsc_vme_masters
`default_nettype wire

// *** tb/test_vme_system_controller.sv ***
`include "vsc_defs.svh"
`default_nettype none
module test_vme_system_controller;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int L256 = 40;
    localparam int L1MS = 60;
    localparam int LACF = 20;
    localparam int LHOLD = 10;
    logic clk = 1'b0, rst_n = 1'b0, osc = 1'b0;
    vsc_pkg::vsc_regbus_t regbus = '0;
    vsc_pkg::vsc_arb_in_t arb;
    logic [7:0] rdata, take_dly = 8'h00, d;
    logic [3:0] bus_grant, raise = 4'h0;
    logic slot1 = 1'b1, force_dis = 1'b0, rr = 1'b0, ignore = 1'b0;
    logic iack_in = 1'b0, ds0 = 1'b0, ds1 = 1'b0, brst = 1'b0, acfail = 1'b0;
    logic sysfail = 1'b0, parity = 1'b0;
    logic iack_out, berr_o, berr_oe, sr_o, sr_oe, sck_o, sck_oe, irq_x, irq_y;
    int error_cnt = 0;
    int checked = 0;
    int n;
    int lim[4] = '{`VSC_BERR_32US_CYC, L256, L1MS, 300};

    always #5 clk = ~clk;
    always #31.25 osc = ~osc;

    vsc_top #(
        .BERR_256US_CYC(20'(L256)),
        .BERR_1MS_CYC(20'(L1MS)),
        .ACFAIL_DLY_CYC(20'(LACF)),
        .SYSRST_HOLD_CYC(20'(LHOLD))
    ) i_dut (
        .clk(clk), .rst_n(rst_n), .regbus(regbus), .rdata(rdata),
        .slot1_detect(slot1), .cfg_force_disable(force_dis), .cfg_round_robin(rr),
        .arb_in(arb), .bus_grant(bus_grant), .iack_in(iack_in), .iack_chain_out(iack_out),
        .ds0(ds0), .ds1(ds1), .berr_o(berr_o), .berr_oe(berr_oe),
        .board_reset_in(brst), .acfail_in(acfail), .sysreset_o(sr_o), .sysreset_oe(sr_oe),
        .osc16_in(osc), .sysclk_o(sck_o), .sysclk_oe(sck_oe), .sysfail_in(sysfail),
        .parity_err_in(parity), .irq7_cpu_x(irq_x), .irq7_cpu_y(irq_y)
    );

    vsc_vme_masters i_far (
        .clk(clk), .rst_n(rst_n), .bus_grant(bus_grant), .raise(raise),
        .ignore(ignore), .take_dly(take_dly), .arb(arb)
    );

    task automatic report_and_stop();
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic ran_out();
        error_cnt++;
        $display("mismatch at %0t: wait ran out", $time);
        report_and_stop();
    endtask : ran_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_n(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_n

    function automatic logic pick(input int k);
        case (k)
            0: return berr_oe;
            1: return sr_oe;
            default: return |bus_grant;
        endcase
    endfunction : pick

    task automatic wait_k(input int k, input logic v, input int lim_c, input bit hard,
            output int cnt);
        cnt = 0;
        while (pick(k) !== v && cnt < lim_c) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (hard && cnt >= lim_c) begin
            ran_out();
        end
    endtask : wait_k

    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        @(posedge clk);
        regbus.addr <= a;
        regbus.wdata <= v;
        regbus.wr <= 1'b1;
        @(posedge clk);
        regbus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [7:0] v);
        @(posedge clk);
        regbus.addr <= a;
        regbus.rd <= 1'b1;
        @(posedge clk);
        regbus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic do_reset(input logic s, input logic f, input logic r);
        @(posedge clk);
        rst_n <= 1'b0;
        slot1 <= s;
        force_dis <= f;
        rr <= r;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset

    // Raise requests, then compare the order in which masters took the bus
    task automatic arb_run(input logic [3:0] req, input int sz, input logic [31:0] exp);
        int cnt;
        cnt = 0;
        @(posedge clk);
        raise <= req;
        @(posedge clk);
        raise <= 4'h0;
        while (i_far.order.size() < sz && cnt < 5000) begin
            @(posedge clk);
            cnt++;
        end
        if (cnt >= 5000) begin
            ran_out();
        end
        for (int i = 0; i < sz; i++) begin
            chk(i_far.order[i], exp[8*i +: 8]);
        end
        i_far.order.delete();
    endtask : arb_run

    task automatic chk_irq(input logic [1:0] exp);
        repeat (3) @(posedge clk);
        #1;
        chk(8'({irq_y, irq_x}), 8'(exp));
    endtask : chk_irq

    initial begin
        do_reset(1'b1, 1'b0, 1'b0);
        chk(8'(sr_oe), 8'h01);
        chk(8'({berr_o, sr_o}), 8'h00);
        rd(`VSC_STATUS_ADDR, d);
        chk(d, 8'h01);
        rd(32'hfe3a0020, d);
        chk(d, 8'h00);
        rd(`VSC_TSEL_B0_SET, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            #17.3;
            chk(8'({sck_oe, sck_o}), 8'({1'b1, osc}));
        end
        // Each select code, varying data, varying strobes
        for (int c = 0; c < 4; c++) begin
            wr(c[0] ? `VSC_TSEL_B0_SET : `VSC_TSEL_B0_CLR, 8'(c * 85));
            wr(c[1] ? `VSC_TSEL_B1_SET : `VSC_TSEL_B1_CLR, 8'hff ^ 8'(c));
            rd(`VSC_STATUS_ADDR, d);
            chk(d, 8'h01 | 8'(c << 2));
            @(posedge clk);
            {ds1, ds0} <= 2'(c % 3 + 1);
            wait_k(0, 1'b1, lim[c] + 3, c != 3, n);
            chk_n(n, (c == 3) ? lim[c] + 3 : lim[c], lim[c] + 3);
            @(posedge clk);
            {ds1, ds0} <= 2'b00;
            wait_k(0, 1'b0, 3, 1'b1, n);
        end
        @(posedge clk);
        take_dly <= 8'h14;
        arb_run(4'hf, 4, 32'h00010203);
        @(posedge clk);
        ignore <= 1'b1;
        raise <= 4'h4;
        @(posedge clk);
        raise <= 4'h0;
        wait_k(2, 1'b1, 50, 1'b1, n);
        wait_k(2, 1'b0, 1100, 1'b1, n);
        chk_n(n, 999, 1001);
        wait_k(2, 1'b1, 10, 1'b1, n);
        chk_n(n, 0, 5);
        @(posedge clk);
        ignore <= 1'b0;
        arb_run(4'h0, 1, 32'h02);
        @(posedge clk);
        iack_in <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(8'(iack_out), 8'h01);
        @(posedge clk);
        iack_in <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(8'(iack_out), 8'h00);
        @(posedge clk);
        sysfail <= 1'b1;
        wr(`VSC_SYSFAIL_EN_ADDR, 8'h04);
        chk_irq(2'b00);
        wr(`VSC_GRP7_CPUX_ADDR, 8'h00);
        chk_irq(2'b01);
        wr(`VSC_GRP7_CPUY_ADDR, 8'h00);
        chk_irq(2'b10);
        wr(`VSC_SYSFAIL_DIS_ADDR, 8'h04);
        chk_irq(2'b00);
        @(posedge clk);
        parity <= 1'b1;
        chk_irq(2'b10);
        @(posedge clk);
        parity <= 1'b0;
        wr(`VSC_SYSFAIL_EN_ADDR, 8'h04);
        @(posedge clk);
        brst <= 1'b1;
        repeat (3) @(posedge clk);
        brst <= 1'b0;
        wait_k(1, 1'b1, 2, 1'b1, n);
        wait_k(1, 1'b0, 40, 1'b1, n);
        chk_n(n, LHOLD - 1, LHOLD + 3);
        rd(`VSC_STATUS_ADDR, d);
        chk(d, 8'h01);
        @(posedge clk);
        sysfail <= 1'b0;
        acfail <= 1'b1;
        wait_k(1, 1'b1, LACF + 10, 1'b1, n);
        chk_n(n, LACF, LACF + 4);
        @(posedge clk);
        acfail <= 1'b0;
        wait_k(1, 1'b0, 4 * LHOLD + LACF, 1'b1, n);
        do_reset(1'b1, 1'b0, 1'b1);
        rd(`VSC_STATUS_ADDR, d);
        chk(d, 8'h03);
        arb_run(4'h8, 1, 32'h03);
        arb_run(4'h5, 2, 32'h0200);
        do_reset(1'b1, 1'b1, 1'b0);
        rd(`VSC_STATUS_ADDR, d);
        chk(d, 8'h00);
        @(posedge clk);
        raise <= 4'h1;
        iack_in <= 1'b1;
        @(posedge clk);
        raise <= 4'h0;
        wait_k(2, 1'b1, 30, 1'b0, n);
        chk_n(n, 30, 30);
        chk(8'({sck_oe, sr_oe, iack_out}), 8'h00);
        @(posedge clk);
        iack_in <= 1'b0;
        do_reset(1'b0, 1'b0, 1'b0);
        rd(`VSC_STATUS_ADDR, d);
        chk(d, 8'h00);
        @(posedge clk);
        raise <= 4'h1;
        @(posedge clk);
        raise <= 4'h0;
        wait_k(2, 1'b1, 30, 1'b0, n);
        chk_n(n, 30, 30);
        report_and_stop();
    end
endmodule : test_vme_system_controller
`default_nettype wire
